// ==== htc_defines.vh ====
// Constants for the hyp trap-control register bank
`ifndef HTC_DEFINES_VH
`define HTC_DEFINES_VH

// ==========================================================
// Coprocessor transfer encodings
`define HTC_OPC1 3'h4
`define HTC_CRN 4'h1
`define HTC_CRM 4'h1
`define HTC_HYP_DEBUG_TRAP_CTRL_OPC2 3'h1
`define HTC_HYP_COPROC_TRAP_REG_OPC2 3'h2

// ==========================================================
// Processor modes
`define HTC_MODE_USR 5'h10
`define HTC_MODE_MON 5'h16
`define HTC_MODE_HYP 5'h1a

// ==========================================================
// Debug control register fields
`define HTC_PART_MSB 4
`define HTC_PART_LSB 0
`define HTC_MONCTL_TRAP_BIT_BIT 5
`define HTC_TPM_BIT 6
`define HTC_HYP_MONITOR_ENABLE_BIT 7
`define HTC_TDE_BIT 8
`define HTC_TDA_BIT 9
`define HTC_DEBUG_OS_REG_TRAP_BIT 10
`define HTC_DEBUG_ROM_TRAP_BIT 11
`define HTC_PART_RST 5'h04
`define HTC_NUM_CNTR 4

// ==========================================================
// Coprocessor trap register fields
`define HTC_CPTR_MASK 32'h8000bfff
`define HTC_CPTR_RST 32'h00000000
`define HTC_CP_BITS 14
`define HTC_TASE_BIT 15
`define HTC_NSASEDIS_BIT 15
`define HTC_CP_FP 4'ha
`define HTC_CP_DBG 4'he
`define HTC_CP_SYS 4'hf

`endif

// ==== htc_counter_split.v ====
// Per-counter partition decode for the performance monitor counters
`timescale 1ns/10ps
`include "htc_defines.vh"

module htc_counter_split (
  input wire [4:0] partition,
  input wire hypMonitorEnable,
  output wire [`HTC_NUM_CNTR-1:0] nsPl1Access,
  output wire [`HTC_NUM_CNTR-1:0] unprivEnable,
  output wire [`HTC_NUM_CNTR-1:0] hypEnable
);

  genvar i;
  generate
    for (i = 0; i < `HTC_NUM_CNTR; i = i + 1)
    begin : gCnt
      wire lowRange;
      assign lowRange = ({27'h0000000, partition} > i);
      assign nsPl1Access[i] = lowRange;
      assign unprivEnable[i] = lowRange;
      // Upper range belongs to PL2 and is gated by the enable
      assign hypEnable[i] = lowRange | hypMonitorEnable;
    end
  endgenerate

endmodule

// ==== htc_coproc_trap.v ====
// Hyp coprocessor trap register with secure-side override
`timescale 1ns/10ps
`include "htc_defines.vh"

module htc_coproc_trap (
  input wire clk_sys,
  input wire reset_n,
  input wire wrEn,
  input wire [31:0] wrData,
  input wire nsAccess,
  input wire [15:0] nonsecureAccessCtrl,
  output wire [31:0] readView,
  output wire [31:0] effective
);

  reg [31:0] cptr_r;
  reg [31:0] cptr_nxt;
  wire [31:0] forced;

  // ==========================================================
  // Bits forced to one where secure side forbids use
  genvar i;
  generate
    for (i = 0; i < 32; i = i + 1)
    begin : gForce
      if (i < `HTC_CP_BITS)
      begin : gCp
        assign forced[i] = ~nonsecureAccessCtrl[i];
      end
      else if (i == `HTC_TASE_BIT)
      begin : gSimd
        assign forced[i] = nonsecureAccessCtrl[`HTC_NSASEDIS_BIT];
      end
      else
      begin : gNone
        assign forced[i] = 1'b0;
      end
    end
  endgenerate

  // Secure override always wins for non-secure use
  assign effective = cptr_r | forced;
  assign readView = nsAccess ? effective : cptr_r;

  // ==========================================================
  // Storage; forced bits ignore non-secure writes
  always @*
  begin
    cptr_nxt = cptr_r;
    if (wrEn)
    begin
      if (nsAccess)
        cptr_nxt = (cptr_r & (forced | ~`HTC_CPTR_MASK)) | (wrData & `HTC_CPTR_MASK & ~forced);
      else
        cptr_nxt = (cptr_r & ~`HTC_CPTR_MASK) | (wrData & `HTC_CPTR_MASK);
    end
  end

  always @(posedge clk_sys)
  begin
    if (!reset_n)
      cptr_r <= `HTC_CPTR_RST;
    else
      cptr_r <= cptr_nxt;
  end

endmodule

// ==== htc_hyp_trap_control.v ====
// Hyp debug control and coprocessor trap register bank
// Behaviour
// - Perfmon trap bit traps non-secure monitor accesses
// - Monctl trap bit traps non-secure control accesses
// - Hold five-bit counter partition field
// - Low counters: PL1, PL2 and unprivileged access
// - High counters: PL2 only, gated by enable
// - Partition resets to four
// - Debug control reached by opc1 4, c1, c1, 2nd 1
// - Coprocessor trap register governs coprocessor and FP traps
// - Hyp FP access obeys secure control, not COPROC_ACCESS_CTRL
// - Trap register only from Hyp or Monitor with NS
// - Secure-forbidden bits read one, ignore writes from Hyp
// - Hyp monitor enable gates hyp-owned counters
`timescale 1ns/10ps
`include "htc_defines.vh"

module htc_hyp_trap_control (
  input wire clk_sys,
  input wire reset_n,
  input wire cpReqValid,
  input wire cpReqWrite,
  input wire [2:0] cpOpc1,
  input wire [3:0] cpCrn,
  input wire [3:0] cpCrm,
  input wire [2:0] cpOpc2,
  input wire [31:0] cpWdata,
  output wire cpRspValid,
  output wire cpRspUndef,
  output wire [31:0] cpRdata,
  input wire [4:0] cpuMode,
  input wire secureCfgNonsecureBit,
  input wire [15:0] nonsecureAccessCtrl,
  input wire pmuReqValid,
  input wire pmuReqCtrl,
  input wire pmuReqCounter,
  input wire [4:0] pmuReqIndex,
  output wire pmuTrapHyp,
  output wire pmuDenied,
  output wire [`HTC_NUM_CNTR-1:0] counterNsPl1Access,
  output wire [`HTC_NUM_CNTR-1:0] counterUnprivEnable,
  output wire [`HTC_NUM_CNTR-1:0] counterHypEnable,
  input wire copReqValid,
  input wire [3:0] copReqNum,
  input wire copReqSimd,
  output wire copTrapHyp,
  output wire copUndef,
  output wire debugRomTrap,
  output wire debugOsRegTrap,
  output wire debugRegTrap,
  output wire debugExceptionTrap
);

  // ==========================================================
  // Decode helpers
  function regHit;
    input [2:0] opc1;
    input [3:0] crn;
    input [3:0] crm;
    input [2:0] opc2;
    input [2:0] want;
    begin
      regHit = (opc1 == `HTC_OPC1) && (crn == `HTC_CRN) && (crm == `HTC_CRM) && (opc2 == want);
    end
  endfunction

  function permitted;
    input [4:0] mode;
    input scrNs;
    begin
      permitted = (mode == `HTC_MODE_HYP) || ((mode == `HTC_MODE_MON) && scrNs);
    end
  endfunction

  // ==========================================================
  // State
  reg [4:0] partition_r;
  reg [4:0] partition_nxt;
  reg perfmonTrapBit_r;
  reg perfmonTrapBit_nxt;
  reg monctlTrapBit_r;
  reg monctlTrapBit_nxt;
  reg hypMonitorEnable_r;
  reg hypMonitorEnable_nxt;
  reg [3:0] debugTrap_r;
  reg [3:0] debugTrap_nxt;
  reg rspValid_r;
  reg rspUndef_r;
  reg [31:0] rdata_r;
  reg [31:0] rdata_nxt;
  reg pmuTrap_r;
  reg pmuTrap_nxt;
  reg pmuDenied_r;
  reg pmuDenied_nxt;
  reg copTrap_r;
  reg copTrap_nxt;
  reg copUndef_r;
  reg copUndef_nxt;

  wire hdcrHit;
  wire cptrHit;
  wire modeOk;
  wire accessOk;
  wire hdcrWrite;
  wire cptrWrite;
  wire nsState;
  wire isUser;
  wire isHyp;
  wire nsLowPriv;
  wire [31:0] hdcrView;
  wire [31:0] cptrView;
  wire [31:0] cptrEff;
  wire [`HTC_NUM_CNTR-1:0] nsPl1Vec;
  wire [`HTC_NUM_CNTR-1:0] unprivVec;
  wire [`HTC_NUM_CNTR-1:0] hypVec;
  wire idxImpl;
  wire cpBitSet;
  wire regRead;
  wire [1:0] cntSel;
  wire lowOk;
  wire hypOk;
  wire fpNum;

  // ==========================================================
  // Mode and security state
  assign isUser = (cpuMode == `HTC_MODE_USR);
  assign isHyp = (cpuMode == `HTC_MODE_HYP);
  assign nsState = secureCfgNonsecureBit && (cpuMode != `HTC_MODE_MON);
  assign nsLowPriv = nsState && !isHyp;

  // ==========================================================
  // Coprocessor register access decode
  assign hdcrHit = regHit(cpOpc1, cpCrn, cpCrm, cpOpc2, `HTC_HYP_DEBUG_TRAP_CTRL_OPC2);
  assign cptrHit = regHit(cpOpc1, cpCrn, cpCrm, cpOpc2, `HTC_HYP_COPROC_TRAP_REG_OPC2);
  assign modeOk = permitted(cpuMode, secureCfgNonsecureBit);
  assign accessOk = (hdcrHit || cptrHit) && modeOk;
  // Blocked accesses change nothing
  assign hdcrWrite = cpReqValid && cpReqWrite && hdcrHit && modeOk;
  assign cptrWrite = cpReqValid && cpReqWrite && cptrHit && modeOk;

  assign hdcrView = {20'h00000, debugTrap_r, hypMonitorEnable_r, perfmonTrapBit_r,
                     monctlTrapBit_r, partition_r};

  // ==========================================================
  // Debug control register fields
  always @*
  begin
    partition_nxt = partition_r;
    perfmonTrapBit_nxt = perfmonTrapBit_r;
    monctlTrapBit_nxt = monctlTrapBit_r;
    hypMonitorEnable_nxt = hypMonitorEnable_r;
    debugTrap_nxt = debugTrap_r;
    if (hdcrWrite)
    begin
      partition_nxt = cpWdata[`HTC_PART_MSB:`HTC_PART_LSB];
      perfmonTrapBit_nxt = cpWdata[`HTC_TPM_BIT];
      monctlTrapBit_nxt = cpWdata[`HTC_MONCTL_TRAP_BIT_BIT];
      hypMonitorEnable_nxt = cpWdata[`HTC_HYP_MONITOR_ENABLE_BIT];
      // Illegal trap combinations are stored as written
      debugTrap_nxt = cpWdata[`HTC_DEBUG_ROM_TRAP_BIT:`HTC_TDE_BIT];
    end
  end

  // ==========================================================
  // Read data and response
  // Refused reads return zero so nothing leaks
  assign regRead = cpReqValid && !cpReqWrite && accessOk;

  always @*
  begin
    rdata_nxt = 32'h00000000;
    if (regRead)
    begin
      if (hdcrHit)
        rdata_nxt = hdcrView;
      else
        rdata_nxt = cptrView;
    end
  end

  // ==========================================================
  // Performance monitor trap decisions
  assign idxImpl = (pmuReqIndex < `HTC_NUM_CNTR);
  assign cntSel = pmuReqIndex[1:0];
  // User mode also needs the unprivileged enable
  assign lowOk = nsPl1Vec[cntSel] && (!isUser || unprivVec[cntSel]);
  assign hypOk = hypVec[cntSel];

  always @*
  begin
    pmuTrap_nxt = 1'b0;
    pmuDenied_nxt = 1'b0;
    if (pmuReqValid && nsLowPriv)
    begin
      if (perfmonTrapBit_r)
        pmuTrap_nxt = 1'b1;
      else if (pmuReqCtrl && monctlTrapBit_r)
        pmuTrap_nxt = 1'b1;
      else if (pmuReqCounter && idxImpl)
        pmuDenied_nxt = !lowOk;
    end
    else if (pmuReqValid && nsState && pmuReqCounter && idxImpl)
    begin
      pmuDenied_nxt = !hypOk;
    end
  end

  // ==========================================================
  // Coprocessor trap decisions
  assign cpBitSet = ((copReqNum < `HTC_CP_BITS) && cptrEff[copReqNum]) ||
                    (copReqSimd && cptrEff[`HTC_TASE_BIT]);
  // Cp10 and cp11 both decode as floating-point numbers
  assign fpNum = (copReqNum[3:1] == (`HTC_CP_FP >> 1));

  always @*
  begin
    copTrap_nxt = 1'b0;
    copUndef_nxt = 1'b0;
    if (copReqValid && nsState && (copReqNum != `HTC_CP_DBG) && (copReqNum != `HTC_CP_SYS))
    begin
      if (isHyp)
        // Hyp ignores COPROC_ACCESS_CTRL; forbidden or trapped cp10/cp11 use faults locally, other numbers pass
        copUndef_nxt = cpBitSet && fpNum;
      else
        copTrap_nxt = cpBitSet;
    end
  end

  // ==========================================================
  // Registers
  always @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      partition_r <= `HTC_PART_RST;
      perfmonTrapBit_r <= 1'b0;
      monctlTrapBit_r <= 1'b0;
      hypMonitorEnable_r <= 1'b0;
      debugTrap_r <= 4'h0;
      rspValid_r <= 1'b0;
      rspUndef_r <= 1'b0;
      rdata_r <= 32'h00000000;
      pmuTrap_r <= 1'b0;
      pmuDenied_r <= 1'b0;
      copTrap_r <= 1'b0;
      copUndef_r <= 1'b0;
    end
    else
    begin
      partition_r <= partition_nxt;
      perfmonTrapBit_r <= perfmonTrapBit_nxt;
      monctlTrapBit_r <= monctlTrapBit_nxt;
      hypMonitorEnable_r <= hypMonitorEnable_nxt;
      debugTrap_r <= debugTrap_nxt;
      rspValid_r <= cpReqValid;
      rspUndef_r <= cpReqValid && !accessOk;
      rdata_r <= rdata_nxt;
      pmuTrap_r <= pmuTrap_nxt;
      pmuDenied_r <= pmuDenied_nxt;
      copTrap_r <= copTrap_nxt;
      copUndef_r <= copUndef_nxt;
    end
  end

  // ==========================================================
  // Submodules
  htc_coproc_trap uCptr (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wrEn(cptrWrite),
    .wrData(cpWdata),
    .nsAccess(nsState),
    .nonsecureAccessCtrl(nonsecureAccessCtrl),
    .readView(cptrView),
    .effective(cptrEff)
  );

  htc_counter_split uSplit (
    .partition(partition_r),
    .hypMonitorEnable(hypMonitorEnable_r),
    .nsPl1Access(nsPl1Vec),
    .unprivEnable(unprivVec),
    .hypEnable(hypVec)
  );

  // ==========================================================
  // Outputs
  assign cpRspValid = rspValid_r;
  assign cpRspUndef = rspUndef_r;
  assign cpRdata = rdata_r;
  assign pmuTrapHyp = pmuTrap_r;
  assign pmuDenied = pmuDenied_r;
  assign counterNsPl1Access = nsPl1Vec;
  assign counterUnprivEnable = unprivVec;
  assign counterHypEnable = hypVec;
  assign copTrapHyp = copTrap_r;
  assign copUndef = copUndef_r;
  assign debugRomTrap = debugTrap_r[3];
  assign debugOsRegTrap = debugTrap_r[2];
  assign debugRegTrap = debugTrap_r[1];
  assign debugExceptionTrap = debugTrap_r[0];

endmodule

// ==== htc_hyp_trap_control_asserts.sv ====
// Assertion checker for the hyp trap-control bank
`timescale 1ns/10ps
`include "htc_defines.vh"
module htc_hyp_trap_control_asserts (
  input logic clk_sys,
  input logic reset_n,
  input logic cpReqValid,
  input logic [2:0] cpOpc1,
  input logic cpRspValid,
  input logic cpRspUndef,
  input logic [31:0] cpRdata,
  input logic [4:0] cpuMode,
  input logic secureCfgNonsecureBit,
  input logic pmuReqValid,
  input logic pmuTrapHyp,
  input logic [3:0] counterNsPl1Access,
  input logic [3:0] counterUnprivEnable,
  input logic [3:0] counterHypEnable,
  input logic copReqValid,
  input logic [3:0] copReqNum,
  input logic copTrapHyp,
  input logic copUndef
);
  // ========
  // Properties
  wire isHyp = cpuMode == `HTC_MODE_HYP;
  wire isMon = cpuMode == `HTC_MODE_MON;
  wire allowed = isHyp | (isMon & secureCfgNonsecureBit);
  wire nsState = secureCfgNonsecureBit & ~isMon;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  AST_RSP_LAT: assert property (cpReqValid |=> cpRspValid)
    else $error("no response after request");
  AST_RSP_SRC: assert property (cpRspValid |-> $past(cpReqValid))
    else $error("response without request");
  AST_MODE: assert property (cpReqValid && !allowed |=> cpRspUndef && cpRdata == 32'h0)
    else $error("disallowed mode not refused");
  AST_ENC: assert property (cpReqValid && cpOpc1 != `HTC_OPC1 |=> cpRspUndef)
    else $error("bad encoding not refused");
  AST_UNPRIV: assert property (counterUnprivEnable == counterNsPl1Access)
    else $error("unprivileged enable differs");
  AST_HYP_LOW: assert property ((counterNsPl1Access & ~counterHypEnable) == 4'h0)
    else $error("low counter not open to hyp");
  AST_PMU_SEC: assert property (pmuReqValid && !nsState |=> !pmuTrapHyp)
    else $error("secure monitor access trapped");
  AST_PMU_SRC: assert property (pmuTrapHyp |-> $past(pmuReqValid))
    else $error("trap without request");
  AST_COP_SYS: assert property (copReqValid && copReqNum >= `HTC_CP_DBG |=> !copTrapHyp && !copUndef)
    else $error("debug or system cp trapped");
  AST_COP_HYP: assert property (copReqValid && isHyp |=> !copTrapHyp)
    else $error("hyp access trapped to hyp");
endmodule

// ==== htc_hyp_trap_control_tb.sv ====
// Self-checking bench for the hyp trap-control bank
`timescale 1ns/10ps
`include "htc_defines.vh"
module htc_hyp_trap_control_tb;
  logic clk_sys, reset_n, cpReqValid, cpReqWrite, cpRspValid, cpRspUndef;
  logic [2:0] cpOpc1, cpOpc2;
  logic [3:0] cpCrn, cpCrm, copReqNum;
  logic [31:0] cpWdata, cpRdata, rdMask;
  logic [4:0] cpuMode, pmuReqIndex;
  logic secureCfgNonsecureBit, pmuReqValid, pmuReqCtrl, pmuReqCounter, pmuTrapHyp, pmuDenied;
  logic [15:0] nonsecureAccessCtrl;
  logic [`HTC_NUM_CNTR-1:0] counterNsPl1Access, counterUnprivEnable, counterHypEnable;
  logic copReqValid, copReqSimd, copTrapHyp, copUndef;
  logic debugRomTrap, debugOsRegTrap, debugRegTrap, debugExceptionTrap;
  logic [3:0] dbgSet [6] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'he, 4'hf};
  int miscompares, checked, i;
  localparam logic [2:0] DBG = `HTC_HYP_DEBUG_TRAP_CTRL_OPC2;
  localparam logic [2:0] CPT = `HTC_HYP_COPROC_TRAP_REG_OPC2;
  localparam logic [4:0] HYP = `HTC_MODE_HYP;
  localparam logic [4:0] MON = `HTC_MODE_MON;
  localparam logic [4:0] SVC = 5'h13;

  htc_hyp_trap_control u_htc_hyp_trap_control (.*);

  // ========
  // Clock and tasks
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic md(input logic [4:0] m, input logic ns, input logic [15:0] nsac);
    @(posedge clk_sys);
    cpuMode <= m;
    secureCfgNonsecureBit <= ns;
    nonsecureAccessCtrl <= nsac;
  endtask

  task automatic cp(input logic wr, input logic [2:0] op2, input logic [31:0] d, input logic und,
                    input logic [31:0] exp);
    @(posedge clk_sys);
    cpReqValid <= 1'b1;
    cpReqWrite <= wr;
    cpOpc2 <= op2;
    cpWdata <= d;
    @(posedge clk_sys);
    cpReqValid <= 1'b0;
    #1;
    chk(cpRspValid, 1'b1, "response");
    chk(cpRspUndef, und, "undef");
    if (!wr)
      chk(cpRdata & rdMask, exp, "read data");
  endtask

  task automatic pmu(input logic ctl, input logic [4:0] idx, input logic trap, input logic den);
    @(posedge clk_sys);
    pmuReqValid <= 1'b1;
    pmuReqCtrl <= ctl;
    pmuReqCounter <= !ctl;
    pmuReqIndex <= idx;
    @(posedge clk_sys);
    pmuReqValid <= 1'b0;
    #1;
    chk(pmuTrapHyp, trap, "monitor trap");
    chk(pmuDenied, den, "counter denial");
  endtask

  task automatic cop(input logic [3:0] num, input logic simd, input logic trap, input logic und);
    @(posedge clk_sys);
    copReqValid <= 1'b1;
    copReqNum <= num;
    copReqSimd <= simd;
    @(posedge clk_sys);
    copReqValid <= 1'b0;
    #1;
    chk(copTrapHyp, trap, "cop trap");
    chk(copUndef, und, "cop undef");
  endtask

  task automatic final_report;
    $display("Checked %0d, miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ========
  // Sequence
  initial
  begin
    {cpReqValid, cpReqWrite, pmuReqValid, pmuReqCtrl, pmuReqCounter, copReqValid, copReqSimd} = '0;
    cpOpc1 = `HTC_OPC1;
    cpCrn = `HTC_CRN;
    cpCrm = `HTC_CRM;
    {cpOpc2, cpWdata, pmuReqIndex, copReqNum} = '0;
    cpuMode = HYP;
    secureCfgNonsecureBit = 1'b1;
    nonsecureAccessCtrl = 16'h3fff;
    reset_n = 1'b0;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    // Enable bit resets to zero, but it is masked from this read
    rdMask = 32'hffffff7f;
    cp(0, DBG, 0, 0, 32'h4);
    rdMask = '1;
    chk(counterNsPl1Access, 4'hf, "split");
    chk({debugRomTrap, debugOsRegTrap, debugRegTrap, debugExceptionTrap}, 4'h0, "dbg");
    cp(0, CPT, 0, 0, 0);
    $display("Done: reset");
    for (i = 0; i <= 4; i++)
    begin
      cp(1, DBG, i, 0, 0);
      cp(0, DBG, 0, 0, i);
      chk(counterNsPl1Access, (32'h1 << i) - 1, "split");
      chk(counterUnprivEnable, (32'h1 << i) - 1, "unpriv");
    end
    $display("Done: partition");
    cp(1, DBG, 32'h62, 0, 0);
    md(SVC, 1, 16'h3fff);
    pmu(0, 1, 1, 0);
    md(HYP, 1, 16'h3fff);
    cp(1, DBG, 32'h22, 0, 0);
    md(SVC, 1, 16'h3fff);
    pmu(1, 0, 1, 0);
    pmu(0, 1, 0, 0);
    pmu(0, 2, 0, 1);
    md(HYP, 1, 16'h3fff);
    pmu(0, 3, 0, 1);
    cp(1, DBG, 32'ha2, 0, 0);
    pmu(0, 3, 0, 0);
    chk(counterHypEnable, 4'hf, "hyp enable");
    md(MON, 1, 16'h3fff);
    pmu(1, 0, 0, 0);
    $display("Done: traps");
    md(`HTC_MODE_USR, 1, 16'h3fff);
    pmu(0, 1, 0, 0);
    pmu(0, 2, 0, 1);
    cp(0, DBG, 0, 1, 0);
    md(SVC, 1, 16'h3fff);
    cp(1, DBG, 0, 1, 0);
    md(MON, 0, 16'h3fff);
    cp(1, CPT, 32'h1, 1, 0);
    md(MON, 1, 16'h3fff);
    cp(0, DBG, 0, 0, 32'ha2);
    cp(0, CPT, 0, 0, 0);
    cp(0, 3'h3, 0, 1, 0);
    @(posedge clk_sys) cpOpc1 <= 3'h0;
    cp(0, DBG, 0, 1, 0);
    @(posedge clk_sys) cpOpc1 <= `HTC_OPC1;
    $display("Done: access");
    md(HYP, 1, 16'h3fff);
    foreach (dbgSet[k])
    begin
      cp(1, DBG, {dbgSet[k], 8'h04}, 0, 0);
      chk({debugRomTrap, debugOsRegTrap, debugRegTrap, debugExceptionTrap}, dbgSet[k], "dbg");
    end
    $display("Done: debug");
    md(MON, 1, 16'h83ff);
    cp(1, CPT, 32'h80000001, 0, 0);
    md(HYP, 1, 16'h83ff);
    cp(0, CPT, 0, 0, 32'h8000bc01);
    cp(1, CPT, 32'hffffffff, 0, 0);
    md(MON, 1, 16'h83ff);
    cp(0, CPT, 0, 0, 32'h800003ff);
    cp(1, CPT, 32'h8, 0, 0);
    md(SVC, 1, 16'h3fff);
    cop(4'h3, 0, 1, 0);
    cop(4'h4, 0, 0, 0);
    cop(`HTC_CP_SYS, 0, 0, 0);
    md(HYP, 1, 16'h3bff);
    cop(`HTC_CP_FP, 0, 0, 1);
    md(HYP, 1, 16'h3fff);
    cop(`HTC_CP_FP, 0, 0, 0);
    md(MON, 1, 16'h3fff);
    cp(1, CPT, 32'h8000, 0, 0);
    md(SVC, 1, 16'h3fff);
    cop(4'h4, 1, 1, 0);
    md(HYP, 1, 16'h3fff);
    cop(4'hb, 1, 0, 1);
    md(MON, 1, 16'h3fff);
    cp(1, CPT, 32'h0, 0, 0);
    md(HYP, 1, 16'hbfff);
    cop(4'hb, 1, 0, 1);
    $display("Done: coprocessor");
    final_report;
  end

  // A hang counts as a mismatch
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    final_report;
  end
endmodule

bind htc_hyp_trap_control htc_hyp_trap_control_asserts u_htc_hyp_trap_control_asserts (.*);
